//--- rtl/i2sf_status.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: unacknowledged master-transmitted byte sets no-ack flag
// RULE2: master TX FIFO write clears no-ack flag
// RULE3: master starvation flag, cleared by master FIFO write
// RULE4: master starved without STOP holds SCL low
// RULE5: slave starvation flag, cleared by slave FIFO write
// RULE6: slave starved after ack holds SCL low
// RULE7: START sets bus-active, STOP clears it
// RULE8: status bit six reads live SCL level
// RULE9: all four flags reset to zero
// RULE10: flags interrupt only when enabled in control
// RULE11: software writes cannot change these status bits
module i2sf_status
  import i2sf_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite slave
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Controller side
  input  wire i2sf_engine_t engine,
  input  wire i2sf_fifo_t   fifo,
  // Bus pins
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              scl_o,
  output logic              scl_oe,
  output logic              irq
);

  // Pin levels after synchronisation
  logic [1:0] pin_lvl;
  logic       scl_lvl, sda_lvl;
  logic       sda_prev_reg, sda_prev_next;
  logic       start_det, stop_det;

  i2sf_sync #(
    .W   (2),
    .RST (I2SF_PIN_RST)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({scl_i, sda_i}),
    .level    (pin_lvl)
  );

  assign scl_lvl = pin_lvl[1];
  assign sda_lvl = pin_lvl[0];

  // START is SDA falling with SCL high, STOP is SDA rising
  always_comb begin
    sda_prev_next = sda_lvl;
    start_det     = scl_lvl && sda_prev_reg && !sda_lvl;
    stop_det      = scl_lvl && !sda_prev_reg && sda_lvl;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sda_prev_reg <= I2SF_PIN_RST[0];
    end else begin
      sda_prev_reg <= sda_prev_next;
    end
  end

  // Flags and their set and clear terms
  logic nack_reg, nack_next;
  logic mreq_reg, mreq_next;
  logic sreq_reg, sreq_next;
  logic active_reg, active_next;
  logic nack_set, mreq_set, sreq_set;
  logic scl_oe_reg, scl_oe_next;

  assign nack_set = engine.byte_done && engine.master_tx && !engine.ack_seen;
  assign mreq_set = engine.byte_done && engine.master_tx
                    && fifo.mtx_empty && !engine.stop_req;
  assign sreq_set = engine.byte_done && engine.slave_tx
                    && engine.ack_seen && fifo.stx_empty;

  // Set wins over a FIFO write in the same cycle
  always_comb begin
    nack_next = nack_reg;
    if (fifo.mtx_write) nack_next = 1'b0;             // RULE2
    if (nack_set) nack_next = 1'b1;                   // RULE1
    mreq_next = mreq_reg;
    if (fifo.mtx_write) mreq_next = 1'b0;             // RULE3
    if (mreq_set) mreq_next = 1'b1;                   // RULE3
    sreq_next = sreq_reg;
    if (fifo.stx_write) sreq_next = 1'b0;             // RULE5
    if (sreq_set) sreq_next = 1'b1;                   // RULE5
    active_next = active_reg;
    if (stop_det) active_next = 1'b0;                 // RULE7
    if (start_det) active_next = 1'b1;                // RULE7
    // Stretch SCL while either transmitter waits for data
    scl_oe_next = mreq_next || sreq_next;             // RULE4 RULE6
  end

  // Flags come only from hardware, never from bus writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nack_reg   <= I2SF_FLAG_RST;                    // RULE9
      mreq_reg   <= I2SF_FLAG_RST;                    // RULE9
      sreq_reg   <= I2SF_FLAG_RST;                    // RULE9
      active_reg <= I2SF_FLAG_RST;                    // RULE9
      scl_oe_reg <= 1'b0;
    end else begin
      nack_reg   <= nack_next;                        // RULE11
      mreq_reg   <= mreq_next;
      sreq_reg   <= sreq_next;
      active_reg <= active_next;
      scl_oe_reg <= scl_oe_next;
    end
  end

  assign scl_oe = scl_oe_reg;
  assign scl_o  = 1'b0;

  // Live status word
  logic [31:0] status_word;
  always_comb begin
    status_word                  = 32'h00000000;
    status_word[I2SF_NACK_BIT]   = nack_reg;
    status_word[I2SF_MREQ_BIT]   = mreq_reg;
    status_word[I2SF_SREQ_BIT]   = sreq_reg;
    status_word[I2SF_ACTIVE_BIT] = active_reg;
    status_word[I2SF_SCL_BIT]    = scl_lvl;           // RULE8
  end

  // Register bus: write channel
  i2sf_wr_state_t wr_state_reg, wr_state_next;
  logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        awready_reg, awready_next, wready_reg, wready_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic        aw_fire, w_fire, wr_do;
  logic [31:0] wr_addr, wr_data;
  logic [3:0]  wr_strb;

  assign aw_fire = s_axi_awvalid && awready_reg;
  assign w_fire  = s_axi_wvalid && wready_reg;
  assign wr_do   = (wr_state_reg == I2SF_WR_IDLE)
                   && (aw_got_reg || aw_fire) && (w_got_reg || w_fire);
  assign wr_addr = aw_fire ? s_axi_awaddr : awaddr_reg;
  assign wr_data = w_fire ? s_axi_wdata : wdata_reg;
  assign wr_strb = w_fire ? s_axi_wstrb : wstrb_reg;

  // Address and data in either order, then one response
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_got_next   = aw_got_reg || aw_fire;
    w_got_next    = w_got_reg || w_fire;
    awaddr_next   = aw_fire ? s_axi_awaddr : awaddr_reg;
    wdata_next    = w_fire ? s_axi_wdata : wdata_reg;
    wstrb_next    = w_fire ? s_axi_wstrb : wstrb_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    ctrl_next     = ctrl_reg;
    case (wr_state_reg)
      I2SF_WR_IDLE: begin
        if (wr_do) begin
          wr_state_next = I2SF_WR_RESP;
          aw_got_next   = 1'b0;
          w_got_next    = 1'b0;
          bvalid_next   = 1'b1;
          bresp_next    = I2SF_RESP_OKAY;
          if (wr_addr == I2SF_CONTROL_ADDR) begin
            for (int b = 0; b < 4; b++) begin
              if (wr_strb[b]) ctrl_next[b*8 +: 8] = wr_data[b*8 +: 8];
            end
          end else if (wr_addr != I2SF_STATUS_ADDR
                       && wr_addr != I2SF_EVENT_ADDR) begin
            bresp_next = I2SF_RESP_SLVERR;
          end
        end
      end
      I2SF_WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_next = I2SF_WR_IDLE;
          bvalid_next   = 1'b0;
        end
      end
      default: begin
        wr_state_next = I2SF_WR_IDLE;
        bvalid_next   = 1'b0;
      end
    endcase
    awready_next = (wr_state_next == I2SF_WR_IDLE) && !aw_got_next;
    wready_next  = (wr_state_next == I2SF_WR_IDLE) && !w_got_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= I2SF_WR_IDLE;
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      awaddr_reg   <= 32'h00000000;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= I2SF_RESP_OKAY;
      ctrl_reg     <= I2SF_CONTROL_RST;
    end else begin
      wr_state_reg <= wr_state_next;
      aw_got_reg   <= aw_got_next;
      w_got_reg    <= w_got_next;
      awaddr_reg   <= awaddr_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      awready_reg  <= awready_next;
      wready_reg   <= wready_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      ctrl_reg     <= ctrl_next;
    end
  end

  // Register bus: read channel and event register
  i2sf_rd_state_t rd_state_reg, rd_state_next;
  logic        arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next, event_reg, event_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic        ar_fire, irq_reg, irq_next;
  logic [31:0] event_set;

  assign ar_fire = s_axi_arvalid && arready_reg;

  always_comb begin
    event_set                  = 32'h00000000;
    event_set[I2SF_NACK_BIT]   = nack_set;
    event_set[I2SF_MREQ_BIT]   = mreq_set;
    event_set[I2SF_SREQ_BIT]   = sreq_set;
    event_set[I2SF_ACTIVE_BIT] = start_det;
  end

  // Read clears the event bits; a new event that cycle survives
  always_comb begin
    rd_state_next = rd_state_reg;
    rvalid_next   = rvalid_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    event_next    = event_reg;
    case (rd_state_reg)
      I2SF_RD_IDLE: begin
        if (ar_fire) begin
          rd_state_next = I2SF_RD_DATA;
          rvalid_next   = 1'b1;
          rresp_next    = I2SF_RESP_OKAY;
          rdata_next    = 32'h00000000;
          case (s_axi_araddr)
            I2SF_STATUS_ADDR:  rdata_next = status_word;  // RULE8
            I2SF_CONTROL_ADDR: rdata_next = ctrl_reg;
            I2SF_EVENT_ADDR: begin
              rdata_next = event_reg;
              event_next = 32'h00000000;
            end
            default:           rresp_next = I2SF_RESP_SLVERR;
          endcase
        end
      end
      I2SF_RD_DATA: begin
        if (s_axi_rready) begin
          rd_state_next = I2SF_RD_IDLE;
          rvalid_next   = 1'b0;
        end
      end
      default: begin
        rd_state_next = I2SF_RD_IDLE;
        rvalid_next   = 1'b0;
      end
    endcase
    event_next   = event_next | event_set;
    arready_next = (rd_state_next == I2SF_RD_IDLE);
    irq_next     = |(event_next & ctrl_next);         // RULE10
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= I2SF_RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h00000000;
      rresp_reg    <= I2SF_RESP_OKAY;
      event_reg    <= I2SF_EVENT_RST;
      irq_reg      <= 1'b0;
    end else begin
      rd_state_reg <= rd_state_next;
      arready_reg  <= arready_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      event_reg    <= event_next;
      irq_reg      <= irq_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign irq           = irq_reg;

  // Checks on flag behaviour
  property p_nack_set;
    @(posedge aclk) disable iff (!aresetn)
    nack_set |=> nack_reg;
  endproperty
  a_nack_set: assert property (p_nack_set)  // RULE1
    else $error("no-ack flag not set after missing ack");

  property p_nack_keep_clear;
    @(posedge aclk) disable iff (!aresetn)
    engine.byte_done && engine.ack_seen && !nack_reg |=> !nack_reg;
  endproperty
  a_nack_keep_clear: assert property (p_nack_keep_clear)  // RULE1
    else $error("no-ack flag set despite ack");

  property p_nack_clear;
    @(posedge aclk) disable iff (!aresetn)
    fifo.mtx_write && !nack_set |=> !nack_reg;
  endproperty
  a_nack_clear: assert property (p_nack_clear)  // RULE2
    else $error("no-ack flag survived master FIFO write");

  property p_mreq;
    @(posedge aclk) disable iff (!aresetn)
    (mreq_set |=> mreq_reg)
    and (mreq_reg && !fifo.mtx_write |=> mreq_reg)
    and (fifo.mtx_write && !mreq_set |=> !mreq_reg);
  endproperty
  a_mreq: assert property (p_mreq)  // RULE3
    else $error("master request flag wrong");

  property p_mhold;
    @(posedge aclk) disable iff (!aresetn)
    mreq_set |=> scl_oe && !scl_o;
  endproperty
  a_mhold: assert property (p_mhold)  // RULE4
    else $error("SCL not held low for starved master");

  property p_sreq;
    @(posedge aclk) disable iff (!aresetn)
    fifo.stx_write && !sreq_set |=> !sreq_reg;
  endproperty
  a_sreq: assert property (p_sreq)  // RULE5
    else $error("slave request flag survived slave FIFO write");

  property p_shold;
    @(posedge aclk) disable iff (!aresetn)
    sreq_set ##1 !fifo.stx_write |=> scl_oe;
  endproperty
  a_shold: assert property (p_shold)  // RULE6
    else $error("SCL released while slave starved");

  property p_active;
    @(posedge aclk) disable iff (!aresetn)
    (start_det |=> active_reg) and (stop_det |=> !active_reg);
  endproperty
  a_active: assert property (p_active)  // RULE7
    else $error("bus-active flag does not follow START/STOP");

  property p_scl_read;
    @(posedge aclk) disable iff (!aresetn)
    ar_fire && s_axi_araddr == I2SF_STATUS_ADDR
      |=> s_axi_rdata[I2SF_SCL_BIT] == $past(scl_lvl);
  endproperty
  a_scl_read: assert property (p_scl_read)  // RULE8
    else $error("status SCL bit differs from line level");

  property p_reset;
    @(posedge aclk)
    !aresetn |=> !nack_reg && !mreq_reg && !sreq_reg && !active_reg;
  endproperty
  a_reset: assert property (p_reset)  // RULE9
    else $error("flags not cleared by reset");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    irq == |(event_reg & ctrl_reg);
  endproperty
  a_irq: assert property (p_irq)  // RULE10
    else $error("interrupt does not match enabled events");

  property p_sw_write;
    @(posedge aclk) disable iff (!aresetn)
    wr_do && wr_addr == I2SF_STATUS_ADDR && !start_det && !stop_det
      |=> $stable(active_reg);
  endproperty
  a_sw_write: assert property (p_sw_write)  // RULE11
    else $error("status write changed bus-active flag");

  c_nack:  cover property (@(posedge aclk) nack_set ##1 fifo.mtx_write);
  c_mhold: cover property (@(posedge aclk) mreq_set ##[1:50] !scl_oe);
  c_busy:  cover property (@(posedge aclk) start_det ##[1:500] stop_det);
  c_irq:   cover property (@(posedge aclk) $rose(irq));

endmodule

//--- rtl/i2sf_pkg.sv
package i2sf_pkg;

  // Register byte addresses on the AXI4-Lite bus
  localparam logic [31:0] I2SF_STATUS_ADDR  = 32'hE010C304;
  localparam logic [31:0] I2SF_CONTROL_ADDR = 32'hE010C308;
  localparam logic [31:0] I2SF_EVENT_ADDR   = 32'hE010C310;

  // Field positions, shared by status, control and event registers; the SCL bit is in status only
  localparam int I2SF_NACK_BIT   = 2;
  localparam int I2SF_MREQ_BIT   = 3;
  localparam int I2SF_SREQ_BIT   = 4;
  localparam int I2SF_ACTIVE_BIT = 5;
  localparam int I2SF_SCL_BIT    = 6;

  // Values after reset
  localparam logic [31:0] I2SF_CONTROL_RST = 32'h00000000;
  localparam logic [31:0] I2SF_EVENT_RST   = 32'h00000000;
  localparam logic        I2SF_FLAG_RST    = 1'h0;
  localparam logic [1:0]  I2SF_PIN_RST     = 2'h3;

  // AXI responses
  localparam logic [1:0] I2SF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] I2SF_RESP_SLVERR = 2'h2;

  // Byte engine report, valid in the cycle a byte finishes
  typedef struct packed {
    logic byte_done;   // One-cycle pulse after the ack slot
    logic ack_seen;    // Receiver drove ack in that slot
    logic master_tx;   // Byte went out as master transmitter
    logic slave_tx;    // Byte went out as slave transmitter
    logic stop_req;    // Byte carried a STOP request
  } i2sf_engine_t;

  // Transmit FIFO view from the CPU side
  typedef struct packed {
    logic mtx_write;   // Byte written into master TX FIFO
    logic stx_write;   // Byte written into slave TX FIFO
    logic mtx_empty;   // Master TX FIFO empty
    logic stx_empty;   // Slave TX FIFO empty
  } i2sf_fifo_t;

  typedef enum logic [1:0] {
    I2SF_WR_IDLE = 2'b01,
    I2SF_WR_RESP = 2'b10
  } i2sf_wr_state_t;

  typedef enum logic [1:0] {
    I2SF_RD_IDLE = 2'b01,
    I2SF_RD_DATA = 2'b10
  } i2sf_rd_state_t;

endpackage

//--- rtl/i2sf_sync.sv
`timescale 1ns/1ps
module i2sf_sync
  import i2sf_pkg::*;
#(
  parameter int         W   = 2,
  parameter logic [1:0] RST = I2SF_PIN_RST
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [W-1:0] lvl_next;

  // Accept a new level only once stages two and three agree
  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
  end

  // Three-stage chain plus filtered level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg  <= RST[W-1:0];
      s2_reg  <= RST[W-1:0];
      s3_reg  <= RST[W-1:0];
      lvl_reg <= RST[W-1:0];
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level = lvl_reg;

endmodule

//--- verif/i2sf_bus_model.sv
`timescale 1ns/1ps
// Far-side bus devices, open drain with pull-ups
module i2sf_bus_model (
  input  wire logic scl_oe,
  output logic      scl_line,
  output logic      sda_line
);
  logic scl_drv;
  logic sda_drv;

  // Wired-AND with pull-up; our stretch pulls SCL low
  assign scl_line = scl_drv & ~scl_oe;
  assign sda_line = sda_drv;

  // Lines released and high outside frames
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // SDA falls under high SCL, then one data bit clocked
  task automatic start_cond();
    #2; // Off the clock edge
    sda_drv = 1'b0;
    #80;
    scl_drv = 1'b0;
    #80;
    sda_drv = 1'b1;
    #80;
    scl_drv = 1'b1;
    #80;
  endtask

  // SDA rises under high SCL, link clock then stands still
  task automatic stop_cond();
    #2; // Off the clock edge
    scl_drv = 1'b0;
    #80;
    sda_drv = 1'b0;
    #80;
    scl_drv = 1'b1;
    #80;
    sda_drv = 1'b1;
    #80;
  endtask
endmodule

//--- verif/i2sf_status_bench.sv
`timescale 1ns/1ps
module i2sf_status_bench import i2sf_pkg::*;;
  localparam logic [31:0] ST  = I2SF_STATUS_ADDR;
  localparam logic [31:0] CT  = I2SF_CONTROL_ADDR;
  localparam logic [31:0] EV  = I2SF_EVENT_ADDR;
  localparam logic [31:0] BAD = 32'hE010C30C;
  localparam logic [1:0]  OK  = I2SF_RESP_OKAY;
  localparam logic [1:0]  ERR = I2SF_RESP_SLVERR;
  logic [31:0]  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic         s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic         scl_i, sda_i, scl_o, scl_oe, irq;
  i2sf_engine_t engine;
  i2sf_fifo_t   fifo;
  logic [33:0]  rexp_q[$];
  logic [1:0]   bexp_q[$];
  logic [31:0]  r;
  int           fail_count, n_compared, cycles;

  i2sf_status i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .engine, .fifo, .scl_i,
    .sda_i, .scl_o, .scl_oe, .irq);
  i2sf_bus_model i_bus (.scl_oe, .scl_line(scl_i), .sda_line(sda_i));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Write: offer both channels, release each when taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] rs = OK);
    logic aw_ok, w_ok;
    bexp_q.push_back(rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // Read: expected word noted for the monitor
  task automatic rd(input logic [31:0] a, d, input logic [1:0] rs = OK);
    rexp_q.push_back({rs, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 0;
  endtask

  // One finished byte from the engine, then settle time
  task automatic pulse(input logic ack, mt, st, sp, me, se);
    @(posedge aclk);
    engine <= i2sf_engine_t'({1'b1, ack, mt, st, sp});
    fifo.mtx_empty <= me;
    fifo.stx_empty <= se;
    @(posedge aclk);
    engine.byte_done <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask

  // Transmit FIFO write strobes
  task automatic fw(input logic m, s);
    @(posedge aclk);
    fifo.mtx_write <= m;
    fifo.stx_write <= s;
    @(posedge aclk);
    fifo.mtx_write <= 1'b0;
    fifo.stx_write <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask

  // Monitor: oldest note against each answer; hang guard
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check("rdata", s_axi_rdata, rexp_q[0][31:0]);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, rexp_q[0][33:32]});
      void'(rexp_q.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, bexp_q[0]});
      void'(bexp_q.pop_front());
    end
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    engine = '0;
    fifo = '0;
    void'($urandom(84584));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ST, 32'h40);
    rd(CT, 32'h0);
    rd(EV, 32'h0);
    rd(BAD, 32'h0, ERR);
    check("scl_oe", {31'h0, scl_oe}, 32'h0);
    $display("test reset done");
    r = $urandom();
    wr(ST, 32'hFFFFFFFF);
    wr(EV, 32'hFFFFFFFF);
    wr(BAD, r, ERR);
    s_axi_wstrb <= 4'h5;
    wr(CT, r);
    s_axi_wstrb <= 4'hF;
    rd(ST, 32'h40);
    rd(EV, 32'h0);
    rd(CT, r & 32'h00FF00FF);
    check("irq", {31'h0, irq}, 32'h0);
    wr(CT, 32'h0);
    $display("test register access done");
    pulse(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    rd(ST, 32'h44);
    fw(1'b1, 1'b0);
    rd(ST, 32'h40);
    pulse(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    rd(ST, 32'h40);
    $display("test no-ack done");
    for (int i = 0; i < 2; i++) begin
      pulse(1'b1, 1'b1, 1'b0, i[0], 1'b1, 1'b0);
      check("scl_oe", {31'h0, scl_oe}, {31'h0, ~i[0]});
      check("scl_o", {31'h0, scl_o}, 32'h0);
      rd(ST, i[0] ? 32'h40 : 32'h08);
      fw(1'b1, 1'b0);
      check("scl_oe", {31'h0, scl_oe}, 32'h0);
      rd(ST, 32'h40);
    end
    $display("test master request done");
    for (int i = 0; i < 2; i++) begin
      pulse(i[0], 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      check("scl_oe", {31'h0, scl_oe}, {31'h0, i[0]});
      rd(ST, i[0] ? 32'h10 : 32'h40);
      fw(1'b0, 1'b1);
      check("scl_oe", {31'h0, scl_oe}, 32'h0);
      rd(ST, 32'h40);
    end
    check("irq", {31'h0, irq}, 32'h0);
    rd(EV, 32'h1C);
    rd(EV, 32'h0);
    $display("test slave request done");
    wr(CT, 32'h4);
    pulse(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    check("irq", {31'h0, irq}, 32'h1);
    rd(EV, 32'h4);
    repeat (3) @(posedge aclk);
    check("irq", {31'h0, irq}, 32'h0);
    fw(1'b1, 1'b0);
    $display("test interrupt done");
    i_bus.start_cond();
    repeat (8) @(posedge aclk);
    rd(ST, 32'h60);
    i_bus.stop_cond();
    repeat (8) @(posedge aclk);
    rd(ST, 32'h40);
    check("irq", {31'h0, irq}, 32'h0);
    rd(EV, 32'h20);
    $display("test bus activity done");
    pulse(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ST, 32'h40);
    rd(CT, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test reset in run done");
    give_verdict();
  end
endmodule
